// *** inc/csb_defines.vh ***
// constants of the chip select bus controller: offsets, fields, reset values, codes
`ifndef CSB_DEFINES_VH
`define CSB_DEFINES_VH

// register byte offsets, one word each; area n block at n*16
`define CSB_OFS_CTRL_LOW 6'h00
`define CSB_OFS_CTRL_HIGH 6'h04
`define CSB_OFS_MASK 6'h08
`define CSB_OFS_START 6'h0c
`define CSB_AREA_STRIDE 4
`define CSB_OFS_DEF_LOW 8'h60
`define CSB_OFS_DEF_HIGH 8'h64
`define CSB_OFS_STATUS 8'h68
`define CSB_OFS_ID 8'h6c

// control low fields
`define CSB_WRW_LSB 4
`define CSB_RDW_LSB 0
// control high fields
`define CSB_EN_BIT 7
`define CSB_MAP_BIT 6
`define CSB_TYPE_LSB 2
`define CSB_WIDTH_LSB 0

// reset values
`define CSB_RST_CTRL_LOW 8'h22
`define CSB_RST_CTRL_HIGH 8'h00
`define CSB_RST_AREA2_HIGH 8'h80
`define CSB_RST_MASK 8'hff
`define CSB_RST_START 8'hff

// memory types
`define CSB_TYPE_SRAM 2'h0
`define CSB_TYPE_SDRAM 2'h3
// bus widths
`define CSB_WIDTH_8 2'h0
`define CSB_WIDTH_16 2'h1
// boot pin codes
`define CSB_BOOT_16 2'h1
`define CSB_BOOT_8 2'h2
// wait codes
`define CSB_WAIT_2 3'h1
`define CSB_WAIT_3 3'h2
`define CSB_WAIT_PIN 3'h3
`define CSB_WAIT_4 3'h5
`define CSB_WAIT_5 3'h6
`define CSB_WAIT_6 3'h7
`define CSB_MIN_STATES 3'h2

`endif

// *** rtl/csb_controller.v ***
// chip select bus controller: area decode, dynamic bus sizing, wait states
// ----------------------------------------------------------------------------
// Functional notes
// - boot pins sampled once after reset release into area 2 bus width
// - reset enables only area 2; other area enables cleared
// - area 2 map select 0 covers whole space; 1 uses start and mask
// - unmasked address bits compared with start; match drives chip select low
// - start register supplies A23..A16; lower bits zero, 64 KB granularity
// - mask bit 0 compares the address bit, 1 ignores it
// - maskable bits: area0 A20..A8, area1 A21..A8, areas2-5 A22..A15
// - area 1 has one shared mask bit for A15..A9
// - priority: on-chip I/O, on-chip memory, then area 0 to 5
// - external access in no enabled area uses default area settings
// - memory type 00 SRAM/ROM, 11 SDRAM, only area 3 may be SDRAM
// - bus width 00 is 8-bit, 01 is 16-bit; SDRAM area uses 01
// - operands split into cycles by width and start address, low byte first
// - 16-bit area: even on low lane, odd on high; unused lane undriven
// - every external cycle lasts at least two states
// - separate three-bit read and write wait fields per area
// - wait codes 001..111 give 2,3,4,5,6 states; 011 selects wait pin
// - fixed mode ends cycle after programmed states regardless of wait pin
// - wait settings ignored for SDRAM areas
// - wait pin mode: high at state two ends cycle, low extends it
// ----------------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
`include "csb_defines.vh"

module csb_controller #(
  parameter [7:0] ID_VALUE = 8'h5a // arbitrary identification value
)
(
  input wire clk,
  input wire rst,
  input wire clk_en,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  // cpu request side
  input wire req_valid,
  input wire req_write,
  input wire [23:0] req_addr,
  input wire [1:0] req_size,
  input wire [31:0] req_wdata,
  input wire req_onchip_io,
  input wire req_onchip_mem,
  output wire req_ready,
  output reg resp_valid,
  output reg [31:0] resp_rdata,
  output reg resp_sdram,
  // external memory pins
  input wire [1:0] boot_width_pins,
  input wire wait_n,
  output reg [23:0] ext_addr,
  output reg [5:0] area_chip_select_n,
  output reg default_area_select,
  output reg rd_n,
  output reg wr_lo_n,
  output reg wr_hi_n,
  input wire [15:0] data_in,
  output reg [15:0] data_out,
  output reg data_lo_oe_n,
  output reg data_hi_oe_n
);

  localparam ST_IDLE = 2'h0;
  localparam ST_CYCLE = 2'h1;
  localparam ST_DONE = 2'h2;

  // ------------------------------------------------------------------------
  // register file
  // ------------------------------------------------------------------------
  reg [7:0] ctrl_low [0:5];
  reg [7:0] ctrl_high [0:5];
  reg [7:0] mask_reg [0:5];
  reg [7:0] start_reg [0:5];
  reg [7:0] def_low;
  reg [1:0] def_type;
  reg [1:0] def_width;
  reg boot_pending;
  reg ack_q;
  reg [1:0] state;

  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  // a write lands on the edge at which the master samples ack high
  wire bus_wr = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0];
  wire [2:0] reg_area = wb_adr_i[6:4];
  wire [3:0] reg_sub = wb_adr_i[3:0];
  assign wb_ack_o = ack_q;

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1)
    begin : area_regs
      wire hit = bus_wr & (wb_adr_i[7] == 1'b0) & (reg_area == g);
      always @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          ctrl_low[g] <= `CSB_RST_CTRL_LOW;
          // only area 2 comes out of reset enabled
          ctrl_high[g] <= (g == 2) ? `CSB_RST_AREA2_HIGH : `CSB_RST_CTRL_HIGH;
          mask_reg[g] <= `CSB_RST_MASK;
          start_reg[g] <= `CSB_RST_START;
        end
        else if (clk_en)
        begin
          if (hit && reg_sub == `CSB_OFS_CTRL_LOW)
            ctrl_low[g] <= wb_dat_i[7:0];
          if (hit && reg_sub == `CSB_OFS_CTRL_HIGH)
            // map select exists only in area 2
            ctrl_high[g] <= (g == 2) ? wb_dat_i[7:0] : {wb_dat_i[7], 1'b0, wb_dat_i[5:0]};
          else if (g == 2 && boot_pending)
            // boot width goes to area 2 once, after release
            ctrl_high[g][`CSB_WIDTH_LSB+1:`CSB_WIDTH_LSB] <=
              (boot_width_pins == `CSB_BOOT_16) ? `CSB_WIDTH_16 : `CSB_WIDTH_8;
          if (hit && reg_sub == `CSB_OFS_MASK)
            mask_reg[g] <= wb_dat_i[7:0];
          if (hit && reg_sub == `CSB_OFS_START)
            start_reg[g] <= wb_dat_i[7:0];
        end
      end
    end
  endgenerate

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      def_low <= `CSB_RST_CTRL_LOW;
      def_type <= `CSB_TYPE_SRAM;
      def_width <= `CSB_WIDTH_8;
      boot_pending <= 1'b1;
      ack_q <= 1'b0;
    end
    else if (clk_en)
    begin
      boot_pending <= 1'b0;
      ack_q <= bus_req;
      if (bus_wr && wb_adr_i == `CSB_OFS_DEF_LOW)
        def_low <= wb_dat_i[7:0];
      if (bus_wr && wb_adr_i == `CSB_OFS_DEF_HIGH)
      begin
        def_type <= wb_dat_i[3:2];
        def_width <= wb_dat_i[1:0];
      end
    end
  end

  // read data registered with the ack; unmapped reads give zero
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      wb_dat_o <= 32'h0;
    else if (clk_en && bus_req)
    begin
      wb_dat_o <= 32'h0;
      if (!wb_adr_i[7] && reg_area < 3'h6)
      begin
        case (reg_sub)
          `CSB_OFS_CTRL_LOW: wb_dat_o[7:0] <= ctrl_low[reg_area];
          `CSB_OFS_CTRL_HIGH: wb_dat_o[7:0] <= ctrl_high[reg_area];
          `CSB_OFS_MASK: wb_dat_o[7:0] <= mask_reg[reg_area];
          `CSB_OFS_START: wb_dat_o[7:0] <= start_reg[reg_area];
          default: wb_dat_o <= 32'h0;
        endcase
      end
      else if (wb_adr_i == `CSB_OFS_DEF_LOW)
        wb_dat_o[7:0] <= def_low;
      else if (wb_adr_i == `CSB_OFS_DEF_HIGH)
        wb_dat_o[3:0] <= {def_type, def_width};
      else if (wb_adr_i == `CSB_OFS_STATUS)
        wb_dat_o[8:0] <= {state != ST_IDLE, default_area_select, ~area_chip_select_n,
          boot_pending};
      else if (wb_adr_i == `CSB_OFS_ID)
        wb_dat_o[7:0] <= ID_VALUE;
    end
  end

  // ------------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------------
  reg [23:0] cur_addr;
  reg [5:0] raw_hit;
  integer i;
  always @*
  begin
    // start supplies A23..A16, low bits zero mask bit 1 ignores
    // area 0: bit 2 masks A15 alone, bit 1 masks A14..A9 as a group
    raw_hit[0] = (cur_addr[23:21] == start_reg[0][7:5]) &&
      (((cur_addr[20:16] ^ start_reg[0][4:0]) & ~mask_reg[0][7:3]) == 5'h0) &&
      ((cur_addr[15:8] & ~{mask_reg[0][2], {6{mask_reg[0][1]}}, mask_reg[0][0]}) == 8'h0);
    // area 1: A23..A22 always, one shared bit for A15..A9
    raw_hit[1] = (cur_addr[23:22] == start_reg[1][7:6]) &&
      (((cur_addr[21:16] ^ start_reg[1][5:0]) & ~mask_reg[1][7:2]) == 6'h0) &&
      (((cur_addr[15:8]) & ~{{7{mask_reg[1][1]}}, mask_reg[1][0]}) == 8'h0);
    for (i = 2; i < 6; i = i + 1)
      // A23 always compared, A22..A16 maskable, A15 zero unless masked
      raw_hit[i] = (cur_addr[23] == start_reg[i][7]) &&
        (((cur_addr[22:16] ^ start_reg[i][6:0]) & ~mask_reg[i][7:1]) == 7'h0) &&
        ((cur_addr[15] & ~mask_reg[i][0]) == 1'b0);
    // area 2 with map select 0 spans the whole space
    if (!ctrl_high[2][`CSB_MAP_BIT])
      raw_hit[2] = 1'b1;
  end

  reg [5:0] sel_onehot;
  reg [2:0] sel_area;
  reg sel_any;
  integer j;
  always @*
  begin
    sel_onehot = 6'h0;
    sel_area = 3'h0;
    sel_any = 1'b0;
    // lowest enabled area wins; on-chip regions are handled before this
    for (j = 5; j >= 0; j = j - 1)
      if (raw_hit[j] && ctrl_high[j][`CSB_EN_BIT])
      begin
        sel_area = j[2:0];
        sel_any = 1'b1;
      end
    if (sel_any)
      sel_onehot[sel_area] = 1'b1;
  end

  // effective settings of the selected area or the default area
  wire [7:0] eff_low = sel_any ? ctrl_low[sel_area] : def_low;
  wire [1:0] eff_type = sel_any ? ctrl_high[sel_area][`CSB_TYPE_LSB+1:`CSB_TYPE_LSB]
    : def_type;
  wire [1:0] eff_width_raw = sel_any
    ? ctrl_high[sel_area][`CSB_WIDTH_LSB+1:`CSB_WIDTH_LSB] : def_width;
  // sdram honoured only in area 3; reserved codes act as sram
  wire eff_sdram = (eff_type == `CSB_TYPE_SDRAM) && sel_any && (sel_area == 3'h3);
  // sdram always runs 16 bit; reserved widths fall back to 8 bit
  wire eff_wide = eff_sdram | (eff_width_raw == `CSB_WIDTH_16);

  // ------------------------------------------------------------------------
  // transfer sequencer
  // ------------------------------------------------------------------------
  reg cur_write;
  reg [2:0] bytes_left;
  reg [1:0] byte_idx;
  reg [31:0] wdata;
  reg [31:0] rdata;
  reg [2:0] state_cnt;
  reg [2:0] wait_code;

  assign req_ready = (state == ST_IDLE);
  wire req_take = clk_en & req_valid & req_ready & ~req_onchip_io & ~req_onchip_mem;

  // bytes this cycle: 16-bit lane takes two when even and two or more remain
  wire pair = eff_wide & ~cur_addr[0] & (bytes_left > 3'h1);
  wire odd_lane = eff_wide & cur_addr[0];
  wire [7:0] byte0 = wdata[8*byte_idx +: 8];
  wire [7:0] byte1 = wdata[8*(byte_idx+2'h1) +: 8];

  // states to run: wait fields per direction
  reg [2:0] target;
  reg pin_mode;
  always @*
  begin
    pin_mode = 1'b0;
    case (wait_code)
      `CSB_WAIT_2: target = 3'h2;
      `CSB_WAIT_3: target = 3'h3;
      `CSB_WAIT_4: target = 3'h4;
      `CSB_WAIT_5: target = 3'h5;
      `CSB_WAIT_6: target = 3'h6;
      `CSB_WAIT_PIN:
      begin
        target = `CSB_MIN_STATES;
        pin_mode = 1'b1;
      end
      default: target = 3'h3;
    endcase
    // sdram timing belongs to its own controller; use the minimum here
    if (eff_sdram)
    begin
      target = `CSB_MIN_STATES;
      pin_mode = 1'b0;
    end
  end

  // fixed mode ignores wait_n; pin mode ends only with wait_n high
  wire cycle_end = (state_cnt >= target) && (!pin_mode || wait_n);

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      cur_addr <= 24'h0;
      cur_write <= 1'b0;
      bytes_left <= 3'h0;
      byte_idx <= 2'h0;
      wdata <= 32'h0;
      rdata <= 32'h0;
      state_cnt <= 3'h1;
      wait_code <= 3'h0;
      resp_valid <= 1'b0;
      resp_rdata <= 32'h0;
      resp_sdram <= 1'b0;
    end
    else if (clk_en)
    begin
      resp_valid <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (req_take)
          begin
            cur_addr <= req_addr;
            cur_write <= req_write;
            wdata <= req_wdata;
            rdata <= 32'h0;
            byte_idx <= 2'h0;
            bytes_left <= (req_size == 2'h2) ? 3'h4 : ((req_size == 2'h1) ? 3'h2 : 3'h1);
            state <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          // latch this piece's wait code, then run the cycle
          wait_code <= cur_write ? eff_low[`CSB_WRW_LSB+2:`CSB_WRW_LSB]
            : eff_low[`CSB_RDW_LSB+2:`CSB_RDW_LSB];
          state_cnt <= 3'h1;
          state <= ST_CYCLE;
        end
        ST_CYCLE:
        begin
          // at least two states per cycle
          if (!cycle_end)
          begin
            if (state_cnt != 3'h7)
              state_cnt <= state_cnt + 3'h1;
          end
          else
          begin
            // low byte first into the operand
            if (pair)
              rdata[8*byte_idx +: 16] <= data_in;
            else
              rdata[8*byte_idx +: 8] <= odd_lane ? data_in[15:8] : data_in[7:0];
            if ((pair && bytes_left == 3'h2) || (!pair && bytes_left == 3'h1))
            begin
              state <= ST_IDLE;
              resp_valid <= 1'b1;
              resp_sdram <= eff_sdram;
              resp_rdata <= rdata;
              if (pair)
                resp_rdata[8*byte_idx +: 16] <= data_in;
              else
                resp_rdata[8*byte_idx +: 8] <= odd_lane ? data_in[15:8] : data_in[7:0];
            end
            else
              state <= ST_DONE;
            bytes_left <= bytes_left - (pair ? 3'h2 : 3'h1);
            byte_idx <= byte_idx + (pair ? 2'h2 : 2'h1);
            cur_addr <= cur_addr + (pair ? 24'h2 : 24'h1);
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------------
  // pin outputs, registered from the next state
  // ------------------------------------------------------------------------
  wire active = (state == ST_CYCLE) && !cycle_end;
  wire starting = (state == ST_DONE);
  wire drive = (starting || active) && !eff_sdram;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ext_addr <= 24'h0;
      area_chip_select_n <= 6'h3f;
      default_area_select <= 1'b0;
      rd_n <= 1'b1;
      wr_lo_n <= 1'b1;
      wr_hi_n <= 1'b1;
      data_out <= 16'h0;
      data_lo_oe_n <= 1'b1;
      data_hi_oe_n <= 1'b1;
    end
    else if (clk_en)
    begin
      ext_addr <= cur_addr;
      // selects stay high when idle or on-chip access
      area_chip_select_n <= (starting || active) ? ~sel_onehot : 6'h3f;
      default_area_select <= (starting || active) && !sel_any;
      rd_n <= ~(drive && !cur_write);
      // unused lane left undriven with its strobe high
      wr_lo_n <= ~(drive && cur_write && !odd_lane);
      wr_hi_n <= ~(drive && cur_write && (pair || odd_lane));
      data_lo_oe_n <= ~(drive && cur_write && !odd_lane);
      data_hi_oe_n <= ~(drive && cur_write && (pair || odd_lane));
      data_out <= pair ? {byte1, byte0} : (odd_lane ? {byte0, 8'h00} : {8'h00, byte0});
    end
  end

endmodule
`default_nettype wire

// *** sim/csb_controller_props.sv ***
// checker: register answer, select exclusivity and strobe relations
`timescale 1ns/100ps
`default_nettype none
module csb_props (
  input wire clk,
  input wire rst,
  input wire clk_en,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire req_valid,
  input wire req_ready,
  input wire req_onchip_io,
  input wire req_onchip_mem,
  input wire resp_valid,
  input wire [5:0] area_chip_select_n,
  input wire default_area_select,
  input wire rd_n,
  input wire wr_lo_n,
  input wire wr_hi_n,
  input wire data_lo_oe_n,
  input wire data_hi_oe_n
);
  wire onchip = req_onchip_io || req_onchip_mem;
  wire take = req_valid && req_ready && clk_en && !onchip;
  wire strobe = !(rd_n && wr_lo_n && wr_hi_n);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  a_ack_answer: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o)
    else $error("register access not answered");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_min_states: assert property (take |=> !req_ready [*3])
    else $error("access shorter than two states");
  a_onchip_skip: assert property (
    req_valid && req_ready && onchip |=> req_ready)
    else $error("on-chip access taken");
  a_done_bound: assert property (take |-> ##[3:400] resp_valid)
    else $error("access never completed");
  a_resp_pulse: assert property (resp_valid |=> !resp_valid)
    else $error("response longer than one cycle");
  a_one_select: assert property (
    $countones({~area_chip_select_n, default_area_select}) <= 1)
    else $error("two selects active");
  a_idle_quiet: assert property (
    req_ready && $past(req_ready) && $past(req_ready, 2)
    |-> &area_chip_select_n && !default_area_select && !strobe)
    else $error("select or strobe active while idle");
  a_strobe_select: assert property (
    strobe |-> !(&area_chip_select_n) || default_area_select)
    else $error("strobe without a select");
  a_write_lane: assert property (
    (wr_lo_n || !data_lo_oe_n) && (wr_hi_n || !data_hi_oe_n))
    else $error("write strobe on an undriven lane");
  a_read_float: assert property (
    !rd_n |-> data_lo_oe_n && data_hi_oe_n && wr_lo_n && wr_hi_n)
    else $error("lane driven during read");
endmodule
bind csb_controller csb_props u_csb_props (.clk, .rst, .clk_en, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .req_valid, .req_ready, .req_onchip_io, .req_onchip_mem, .resp_valid,
  .area_chip_select_n, .default_area_select, .rd_n, .wr_lo_n, .wr_hi_n, .data_lo_oe_n,
  .data_hi_oe_n);
`default_nettype wire

// *** sim/csb_mem_model.sv ***
// behavioural byte-lane static memory with a wait output
`timescale 1ns/100ps
`default_nettype none
module csb_mem_model (
  input wire logic clk,
  input wire logic [23:0] ext_addr,
  input wire logic [5:0] area_chip_select_n,
  input wire logic default_area_select,
  input wire logic rd_n,
  input wire logic wr_lo_n,
  input wire logic wr_hi_n,
  input wire logic [15:0] data_out,
  output logic [15:0] data_in,
  output logic wait_n
);
  // static contents only: the boot part is never a dynamic memory
  logic [7:0] mem [256];
  logic [15:0] last = 16'h0;
  int n_wait = 0;
  int cnt = 0;
  wire sel = !(&area_chip_select_n) || default_area_select;
  wire [7:0] a = ext_addr[7:0];
  // odd addresses sit on both lanes, even ones on the low lane alone
  wire [7:0] ah = a[0] ? a : a + 8'h1;
  always @(posedge clk)
  begin
    cnt <= sel ? cnt + 1 : 0;
    if (sel && !wr_lo_n)
      mem[a] <= data_out[7:0];
    if (sel && !wr_hi_n)
      mem[ah] <= data_out[15:8];
    if (sel && !rd_n)
      last <= {mem[ah], mem[a]};
  end
  // released lanes show the inverse of the last value, so stale data never matches
  assign data_in = (sel && !rd_n) ? {mem[ah], mem[a]} : ~last;
  // wait held low for n_wait cycles from the select
  assign wait_n = !(sel && cnt < n_wait);
endmodule
`default_nettype wire

// *** sim/csb_controller_tb_top.sv ***
// self-checking bench: registers, area decode, waits and bus sizing
`timescale 1ns/100ps
`default_nettype none
module csb_controller_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic req_onchip_io = 1'b0, req_onchip_mem = 1'b0, def_seen, lo_seen, hi_seen, st, st_q, sd;
  logic [1:0] req_size = 2'h0, boot_width_pins = 2'h1;
  logic [3:0] wb_sel_i = 4'hf;
  logic [7:0] wb_adr_i = 8'h0, n_sel, n_pc;
  logic [5:0] cs_seen;
  logic [23:0] req_addr = 24'h0;
  logic [31:0] wb_dat_i = 32'h0, req_wdata = 32'h0, q;
  logic [7:0] ws [5] = '{8'h2, 8'h3, 8'h4, 8'h5, 8'h6};
  logic [2:0] wc [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
  logic [7:0] mk [6] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h80, 8'hff};
  logic [23:0] ad [6] = '{24'h1101ff, 24'h110200, 24'h11fe00, 24'h110100, 24'h310000,
    24'h510000};
  logic [5:0] ex [6] = '{6'h3d, 6'h3b, 6'h3d, 6'h3b, 6'h3d, 6'h3b};
  int n_mismatch = 0;
  int n_tests = 0;
  wire wb_ack_o, req_ready, resp_valid, resp_sdram, wait_n, default_area_select;
  wire rd_n, wr_lo_n, wr_hi_n, data_lo_oe_n, data_hi_oe_n;
  wire [5:0] area_chip_select_n;
  wire [15:0] data_in, data_out;
  wire [23:0] ext_addr;
  wire [31:0] wb_dat_o, resp_rdata;

  always #50 clk = ~clk;

  csb_controller u_csb_controller (.clk, .rst, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .req_valid, .req_write, .req_addr,
    .req_size, .req_wdata, .req_onchip_io, .req_onchip_mem, .req_ready, .resp_valid,
    .resp_rdata, .resp_sdram, .boot_width_pins, .wait_n, .ext_addr, .area_chip_select_n,
    .default_area_select, .rd_n, .wr_lo_n, .wr_hi_n, .data_in, .data_out, .data_lo_oe_n,
    .data_hi_oe_n);
  csb_mem_model u_csb_mem_model (.clk, .ext_addr, .area_chip_select_n, .default_area_select,
    .rd_n, .wr_lo_n, .wr_hi_n, .data_out, .data_in, .wait_n);

  // per-access observation; counters only move while pins are active, so clearing is safe
  always @(posedge clk)
  begin
    st = rd_n & wr_lo_n & wr_hi_n;
    if (!(&area_chip_select_n) || default_area_select)
    begin
      n_sel++;
      cs_seen &= area_chip_select_n;
      def_seen |= default_area_select;
    end
    n_pc += {7'h0, st_q & !st};
    lo_seen |= !wr_lo_n;
    hi_seen |= !wr_hi_n;
    st_q = st;
  end

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic results;
    $display("mismatches %0d checks %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic ok);
    n_tests++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("BAD t=%0t check failed", $time);
    end
  endtask
  function automatic logic sig(input int k);
    return k == 0 ? wb_ack_o : (k == 1 ? req_ready : resp_valid);
  endfunction
  task automatic wait_for(input int k);
    int i;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (sig(k) !== 1'b1 && i < 300);
    if (sig(k) !== 1'b1)
    begin
      n_mismatch++;
      $display("BAD t=%0t no answer", $time);
      results;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    wait_for(0);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h0);
    chk(q[7:0] === e);
  endtask
  task automatic clr;
    {n_sel, n_pc, cs_seen, def_seen, lo_seen, hi_seen} = {16'h0, 6'h3f, 3'h0};
  endtask
  task automatic cpu(input logic w, input logic [23:0] a, input logic [1:0] s,
    input logic [31:0] d);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_size <= s;
    req_wdata <= d;
    clr;
    wait_for(1);
    req_valid <= 1'b0;
    wait_for(2);
    q = resp_rdata;
    sd = resp_sdram;
  endtask
  task automatic area(input logic [7:0] b, st_v, mk_v, lo, hi);
    wb(1'b1, b + 8'h0c, st_v);
    wb(1'b1, b + 8'h08, mk_v);
    wb(1'b1, b, lo);
    wb(1'b1, b + 8'h04, hi & 8'h7f);
    wb(1'b1, b + 8'h04, hi);
  endtask

  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(8'h00, 8'h22);
    rd(8'h04, 8'h00);
    rd(8'h24, 8'h81);
    rd(8'h28, 8'hff);
    rd(8'h2c, 8'hff);
    rd(8'h64, 8'h00);
    rd(8'h7c, 8'h00);
    cpu(1'b1, 24'habcd10, 2'h2, 32'h44332211);
    chk(cs_seen === 6'h3b && n_pc === 8'h2);
    cpu(1'b0, 24'habcd13, 2'h0, 32'h0);
    chk(q[7:0] === 8'h44 && n_pc === 8'h1);
    area(8'h00, 8'h10, 8'h00, 8'h22, 8'h80);
    u_csb_mem_model.n_wait = 8;
    for (int i = 0; i < 5; i++)
    begin
      wb(1'b1, 8'h00, {1'b0, wc[4 - i], 1'b0, wc[i]});
      cpu(1'b1, 24'h100040, 2'h0, {24'h0, 8'h5a ^ i[7:0]});
      chk(n_sel === ws[4 - i]);
      cpu(1'b0, 24'h100040, 2'h0, 32'h0);
      chk(n_sel === ws[i] && q[7:0] === (8'h5a ^ i[7:0]) && cs_seen === 6'h3e);
    end
    wb(1'b1, 8'h00, 8'h33);
    u_csb_mem_model.n_wait = 0;
    cpu(1'b0, 24'h100040, 2'h0, 32'h0);
    chk(n_sel === 8'h2);
    u_csb_mem_model.n_wait = 4;
    cpu(1'b0, 24'h100040, 2'h0, 32'h0);
    chk(n_sel > 8'h4 && n_sel < 8'h7);
    for (int i = 0; i < 6; i++)
    begin
      area(8'h10, 8'h11, mk[i], 8'h11, 8'h80);
      cpu(1'b0, ad[i], 2'h0, 32'h0);
      chk(cs_seen === ex[i]);
    end
    area(8'h20, 8'hff, 8'h00, 8'h22, 8'hc1);
    wb(1'b1, 8'h60, 8'h55);
    cpu(1'b0, 24'h600000, 2'h0, 32'h0);
    chk(def_seen === 1'b1 && cs_seen === 6'h3f && n_sel === 8'h4);
    cpu(1'b1, 24'h600000, 2'h2, 32'h0);
    chk(n_pc === 8'h4);
    area(8'h10, 8'h11, 8'h01, 8'h11, 8'h81);
    cpu(1'b1, 24'h110001, 2'h2, 32'h44332211);
    chk(n_pc === 8'h3);
    cpu(1'b0, 24'h110001, 2'h2, 32'h0);
    chk(n_pc === 8'h3 && q === 32'h44332211);
    cpu(1'b1, 24'h110003, 2'h0, 32'h77);
    chk(hi_seen === 1'b1 && lo_seen === 1'b0);
    cpu(1'b0, 24'h110002, 2'h1, 32'h0);
    chk(q[15:0] === 16'h7722 && n_pc === 8'h1);
    area(8'h30, 8'h30, 8'h00, 8'h77, 8'h8d);
    cpu(1'b0, 24'h300000, 2'h0, 32'h0);
    chk(sd === 1'b1 && n_sel === 8'h2 && cs_seen === 6'h37);
    wb(1'b1, 8'h04, 8'h8c);
    cpu(1'b0, 24'h100040, 2'h0, 32'h0);
    chk(sd === 1'b0 && cs_seen === 6'h3e);
    area(8'h00, 8'h10, 8'h04, 8'h33, 8'h80);
    cpu(1'b0, 24'h108040, 2'h0, 32'h0);
    chk(cs_seen === 6'h3e);
    for (int i = 0; i < 2; i++)
    begin
      req_onchip_io <= (i == 0);
      req_onchip_mem <= (i == 1);
      req_valid <= 1'b1;
      clr;
      repeat (6) @(posedge clk);
      chk(n_sel === 8'h0 && req_ready === 1'b1);
      req_valid <= 1'b0;
      @(posedge clk);
    end
    boot_width_pins <= 2'h2;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(8'h24, 8'h80);
    rd(8'h04, 8'h00);
    results;
  end
endmodule
`default_nettype wire
